/* rtc_pkg.sv */
// Constants, types and field layouts for the calendar clock core.
// Assumes one 100 MHz clock and a 32.768 kHz crystal level on a pin.
//
// Notes on behaviour
// - Counting and time and alarm values survive while the processor is off.
// - Alarm, periodic event or wakeup input raise a wake request.
// - Alarm or periodic interrupt can be shown on the wakeup pin.
// - Year counts 00 to 99, meaning 2000 to 2099, then wraps.
// - Counts seconds to years; February gets 29 days in leap years.
// - Time, calendar and alarm fields are BCD except binary ms; hours run 00 to 23.
// - Alarm granularity: second, minute, hour, day or week.
// - Day mode fires at an exact hour, minute and second.
// - Periodic event every millisecond, second, minute, hour or day.
// - All interrupt sources merge into one interrupt output.
// - Timebase is the 32.768 kHz crystal; calibration trims per minute.
// - A written value appears only after two further crystal cycles.
// - Writes are ignored while the oscillator is disabled.
// - The power-on reset initialises every register of the core.
// - The device reset pin does not touch any flip-flop here.
// - Wakeup output is open drain: low for zero, released for one.
package rtc_pkg;

    // ********************************
    // Timebase
    // ********************************
    localparam int          XTAL_HZ      = 32768;
    localparam logic [15:0] MS_STEP      = 16'h03e8; // Accumulator step
    localparam logic [11:0] MS_MAX       = 12'h3e7;  // Last millisecond
    localparam logic [1:0]  WR_DELAY     = 2'h2;     // Crystal cycles

    // ********************************
    // Limits and reset values (BCD)
    // ********************************
    localparam logic [7:0]  SEC_MAX      = 8'h59;
    localparam logic [7:0]  HOUR_MAX     = 8'h23;
    localparam logic [7:0]  DOW_MAX      = 8'h07;
    localparam logic [7:0]  MON_MAX      = 8'h12;
    localparam logic [7:0]  YEAR_MAX     = 8'h99;
    localparam logic [7:0]  ZERO_RST     = 8'h00;
    localparam logic [7:0]  ONE_RST      = 8'h01;

    // ********************************
    // Types
    // ********************************
    typedef struct packed {
        logic [7:0]  year;
        logic [7:0]  mon;
        logic [7:0]  day;
        logic [7:0]  dow;
        logic [7:0]  hour;
        logic [7:0]  min;
        logic [7:0]  sec;
        logic [11:0] ms;
    } rtc_time_t;

    typedef struct packed {
        logic [7:0] dow;
        logic [7:0] hour;
        logic [7:0] min;
        logic [7:0] sec;
    } alarm_t;

    typedef enum logic [3:0] {
        W_SEC, W_MIN, W_HOUR, W_DOW, W_DAY, W_MON, W_YEAR,
        W_ASEC, W_AMIN, W_AHOUR, W_ADOW
    } wsel_t;

    typedef struct packed {
        wsel_t      sel;
        logic [7:0] data;
    } wr_t;

    typedef enum logic [2:0] {
        AL_SEC, AL_MIN, AL_HOUR, AL_DAY, AL_WEEK
    } alarm_mode_t;

    typedef enum logic [2:0] {
        PER_MS, PER_SEC, PER_MIN, PER_HOUR, PER_DAY
    } per_sel_t;

endpackage

/* rtc_core.sv */
// Calendar clock core: BCD time and date, alarm, periodic events, wakeup.
// Assumes XTAL_CLK, WAKEUP_I and POWERGOOD come from outside the clock
// domain; all other inputs are driven by logic on CLK.
`timescale 1ns/10ps
module rtc_core
    import rtc_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        SRST,
    input  wire logic        XTAL_CLK,
    input  wire logic        OSC_EN,
    input  wire logic        POWERGOOD,
    input  wire logic        WR_STB,
    input  wire wr_t         WR,
    input  wire logic signed [7:0] CAL,
    input  wire alarm_mode_t ALARM_MODE,
    input  wire logic        ALARM_EN,
    input  wire logic        ALARM_CLR,
    input  wire per_sel_t    PER_SEL,
    input  wire logic        PER_EN,
    input  wire logic        PER_CLR,
    input  wire logic        WU_DIR,
    input  wire logic        WU_DOUT,
    input  wire logic        WAKEUP_I,
    output rtc_time_t        TIME,
    output alarm_t           ALARM,
    output logic             WR_BUSY,
    output logic             ALARM_FLAG,
    output logic             PER_FLAG,
    output logic             IRQ,
    output logic             WAKE_REQ,
    output logic             WAKEUP_O,
    output logic             WAKEUP_OE
);

    // ********************************
    // Helper functions
    // ********************************

    // BCD increment of one byte
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9)
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        else
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
    endfunction

    // Last day of a month, leap years for 2000 to 2099
    function automatic logic [7:0] last_day(input logic [7:0] mon,
                                            input logic [7:0] yr);
        logic leap;
        leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                     : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 ||
                        yr[3:0] == 4'h8);
        if (mon == 8'h02)
            last_day = leap ? 8'h29 : 8'h28;
        else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 ||
                 mon == 8'h11)
            last_day = 8'h30;
        else
            last_day = 8'h31;
    endfunction

    // ********************************
    // Declarations
    // ********************************
    logic        xs1_ff, xs2_ff, xs3_ff;
    logic        ws1_ff, ws2_ff;
    logic        ps1_ff, ps2_ff;
    logic        tick;
    logic [14:0] acc_ff;
    logic [15:0] acc_sum;
    logic        ms_tick;
    rtc_time_t   time_ff, nxt_time;
    alarm_t      alarm_ff;
    logic        pend_ff;
    wr_t         pend_wr_ff;
    logic [1:0]  pend_cnt_ff;
    logic        apply;
    logic [4:0]  carry, evt_ff;
    logic [11:0] ms_last;
    logic        alarm_hit, per_hit;
    logic        nxt_alarm, nxt_per;
    logic        alarm_flag_ff, per_flag_ff, irq_ff;
    logic        wake_ff, wu_oe_ff, wu_o_ff;

    // ********************************
    // Input synchronisers
    // ********************************

    // Two flops for every pin level, third flop only for the edge detect
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            xs1_ff <= 1'b0;
            xs2_ff <= 1'b0;
            xs3_ff <= 1'b0;
            ws1_ff <= 1'b0;
            ws2_ff <= 1'b0;
            ps1_ff <= 1'b0;
            ps2_ff <= 1'b0;
        end
        else
        begin
            xs1_ff <= XTAL_CLK;
            xs2_ff <= xs1_ff;
            xs3_ff <= xs2_ff;
            ws1_ff <= WAKEUP_I;
            ws2_ff <= ws1_ff;
            ps1_ff <= POWERGOOD;
            ps2_ff <= ps1_ff;
        end
    end

    // One crystal cycle, counted only while the oscillator runs
    assign tick = xs2_ff & ~xs3_ff & OSC_EN;

    // ********************************
    // Millisecond timebase
    // ********************************

    // 1000 steps per 32768 crystal cycles gives one carry per millisecond
    assign acc_sum = {1'b0, acc_ff} + MS_STEP;
    assign ms_tick = tick & acc_sum[15];

    always_ff @(posedge CLK)
    begin
        if (SRST)
            acc_ff <= 15'h0000;
        else if (tick)
            acc_ff <= acc_sum[14:0];
    end

    // ********************************
    // Delayed write path
    // ********************************

    // Write lands on the second crystal edge after it is taken
    assign apply = tick & pend_ff & (pend_cnt_ff == WR_DELAY - 2'h1);

    always_ff @(posedge CLK)
    begin
        if (SRST || !ps2_ff)
        begin
            pend_ff     <= 1'b0;
            pend_wr_ff  <= '{sel: W_SEC, data: ZERO_RST};
            pend_cnt_ff <= 2'h0;
        end
        else if (!pend_ff)
        begin
            if (WR_STB && OSC_EN)
            begin
                pend_ff     <= 1'b1;
                pend_wr_ff  <= WR;
                pend_cnt_ff <= 2'h0;
            end
        end
        else if (apply)
            pend_ff <= 1'b0;
        else if (tick)
            pend_cnt_ff <= pend_cnt_ff + 2'h1;
    end

    // ********************************
    // Calendar counting
    // ********************************

    // Calibration lengthens or shortens the first second of each minute
    assign ms_last = (time_ff.sec == ZERO_RST)
                   ? MS_MAX - {{4{CAL[7]}}, CAL} : MS_MAX;

    always_comb
    begin
        nxt_time = time_ff;
        carry    = 5'h00;
        if (ms_tick)
        begin
            carry[0] = 1'b1;
            if (time_ff.ms >= ms_last)
            begin
                nxt_time.ms = 12'h000;
                carry[1]    = 1'b1;
                if (time_ff.sec == SEC_MAX)
                begin
                    nxt_time.sec = ZERO_RST;
                    carry[2]     = 1'b1;
                end
                else
                    nxt_time.sec = bcd_inc(time_ff.sec);
            end
            else
                nxt_time.ms = time_ff.ms + 12'h001;
        end
        if (carry[2])
        begin
            if (time_ff.min == SEC_MAX)
            begin
                nxt_time.min = ZERO_RST;
                carry[3]     = 1'b1;
            end
            else
                nxt_time.min = bcd_inc(time_ff.min);
        end
        if (carry[3])
        begin
            if (time_ff.hour == HOUR_MAX)
            begin
                nxt_time.hour = ZERO_RST;
                carry[4]      = 1'b1;
            end
            else
                nxt_time.hour = bcd_inc(time_ff.hour);
        end
        if (carry[4])
        begin
            nxt_time.dow = (time_ff.dow == DOW_MAX)
                         ? ONE_RST : bcd_inc(time_ff.dow);
            if (time_ff.day == last_day(time_ff.mon, time_ff.year))
            begin
                nxt_time.day = ONE_RST;
                if (time_ff.mon == MON_MAX)
                begin
                    nxt_time.mon  = ONE_RST;
                    nxt_time.year = (time_ff.year == YEAR_MAX)
                                  ? ZERO_RST : bcd_inc(time_ff.year);
                end
                else
                    nxt_time.mon = bcd_inc(time_ff.mon);
            end
            else
                nxt_time.day = bcd_inc(time_ff.day);
        end
        // A landing write overrides the count for its own field
        if (apply)
        begin
            case (pend_wr_ff.sel)
                W_SEC:   nxt_time.sec  = pend_wr_ff.data;
                W_MIN:   nxt_time.min  = pend_wr_ff.data;
                W_HOUR:  nxt_time.hour = pend_wr_ff.data;
                W_DOW:   nxt_time.dow  = pend_wr_ff.data;
                W_DAY:   nxt_time.day  = pend_wr_ff.data;
                W_MON:   nxt_time.mon  = pend_wr_ff.data;
                W_YEAR:  nxt_time.year = pend_wr_ff.data;
                default: nxt_time = nxt_time;
            endcase
        end
    end

    // Time keeps running whatever the processor power state
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            time_ff <= '{year: ZERO_RST, mon: ONE_RST, day: ONE_RST,
                         dow: ONE_RST, hour: ZERO_RST, min: ZERO_RST,
                         sec: ZERO_RST, ms: 12'h000};
            evt_ff  <= 5'h00;
        end
        else
        begin
            time_ff <= nxt_time;
            evt_ff  <= carry;
        end
    end

    // Alarm setting, written through the same delayed path
    always_ff @(posedge CLK)
    begin
        if (SRST)
            alarm_ff <= '{dow: ONE_RST, hour: ZERO_RST, min: ZERO_RST,
                          sec: ZERO_RST};
        else if (apply)
        begin
            case (pend_wr_ff.sel)
                W_ASEC:  alarm_ff.sec  <= pend_wr_ff.data;
                W_AMIN:  alarm_ff.min  <= pend_wr_ff.data;
                W_AHOUR: alarm_ff.hour <= pend_wr_ff.data;
                W_ADOW:  alarm_ff.dow  <= pend_wr_ff.data;
                default: alarm_ff <= alarm_ff;
            endcase
        end
    end

    // ********************************
    // Alarm and periodic events
    // ********************************

    // Compare the freshly stored time one cycle after a second carry
    always_comb
    begin
        case (ALARM_MODE)
            AL_SEC:  alarm_hit = 1'b1;
            AL_MIN:  alarm_hit = time_ff.sec == alarm_ff.sec;
            AL_HOUR: alarm_hit = time_ff.sec == alarm_ff.sec &&
                                 time_ff.min == alarm_ff.min;
            AL_DAY:  alarm_hit = time_ff.sec == alarm_ff.sec &&
                                 time_ff.min == alarm_ff.min &&
                                 time_ff.hour == alarm_ff.hour;
            AL_WEEK: alarm_hit = time_ff.sec == alarm_ff.sec &&
                                 time_ff.min == alarm_ff.min &&
                                 time_ff.hour == alarm_ff.hour &&
                                 time_ff.dow == alarm_ff.dow;
            default: alarm_hit = 1'b0;
        endcase
        alarm_hit = alarm_hit & evt_ff[1] & ALARM_EN;
        case (PER_SEL)
            PER_MS:   per_hit = evt_ff[0];
            PER_SEC:  per_hit = evt_ff[1];
            PER_MIN:  per_hit = evt_ff[2];
            PER_HOUR: per_hit = evt_ff[3];
            PER_DAY:  per_hit = evt_ff[4];
            default:  per_hit = 1'b0;
        endcase
        per_hit = per_hit & PER_EN;
    end

    // Sticky flags: a new event wins over a clear in the same cycle
    assign nxt_alarm = alarm_hit | (alarm_flag_ff & ~ALARM_CLR);
    assign nxt_per   = per_hit | (per_flag_ff & ~PER_CLR);

    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            alarm_flag_ff <= 1'b0;
            per_flag_ff   <= 1'b0;
            irq_ff        <= 1'b0;
        end
        else
        begin
            alarm_flag_ff <= nxt_alarm;
            per_flag_ff   <= nxt_per;
            irq_ff        <= nxt_alarm | nxt_per;
        end
    end

    // ********************************
    // Wakeup request and pin
    // ********************************

    // Wake on any event, or on the pin while it is an input
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            wake_ff  <= 1'b0;
            wu_oe_ff <= 1'b0;
            wu_o_ff  <= 1'b0;
        end
        else
        begin
            wake_ff  <= nxt_alarm | nxt_per | (~WU_DIR & ws2_ff);
            wu_oe_ff <= WU_DIR & (~WU_DOUT | nxt_alarm | nxt_per);
            wu_o_ff  <= 1'b0;
        end
    end

    // ********************************
    // Outputs
    // ********************************
    assign TIME       = time_ff;
    assign ALARM      = alarm_ff;
    assign WR_BUSY    = pend_ff;
    assign ALARM_FLAG = alarm_flag_ff;
    assign PER_FLAG   = per_flag_ff;
    assign IRQ        = irq_ff;
    assign WAKE_REQ   = wake_ff;
    assign WAKEUP_O   = wu_o_ff;
    assign WAKEUP_OE  = wu_oe_ff;

endmodule

/* rtc_core_checker.sv */
// Concurrent checks on the ports of the calendar clock core.
// Assumes one CLK domain and a crystal no faster than a third of CLK.
`timescale 1ns/10ps
module rtc_core_checker
    import rtc_pkg::*;
(
    input logic      CLK,
    input logic      SRST,
    input logic      OSC_EN,
    input logic      POWERGOOD,
    input logic      WR_STB,
    input logic      PER_EN,
    input logic      PER_CLR,
    input logic      WU_DIR,
    input logic      WU_DOUT,
    input logic      WAKEUP_I,
    input rtc_time_t TIME,
    input logic      WR_BUSY,
    input logic      ALARM_FLAG,
    input logic      PER_FLAG,
    input logic      IRQ,
    input logic      WAKE_REQ,
    input logic      WAKEUP_OE
);
    // ********************************
    // Write path
    // ********************************
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SRST);

    // Write offered while supply has been settled for the sync depth
    sequence s_take;
        WR_STB && OSC_EN && !WR_BUSY && POWERGOOD && $past(POWERGOOD)
            && $past(POWERGOOD, 2) && $past(POWERGOOD, 3)
            && !$past(SRST) && !$past(SRST, 2);
    endsequence
    sequence s_start;
        $rose(WR_BUSY);
    endsequence
    property p_take;
        s_take |=> WR_BUSY;
    endproperty
    a_take: assert property (p_take) else $error("write not taken");
    property p_busy_min;
        s_start |-> WR_BUSY [*3];
    endproperty
    a_busy_min: assert property (p_busy_min) else $error("write early");
    property p_busy_max;
        s_start |-> ##[1:600] !WR_BUSY;
    endproperty
    a_busy_max: assert property (p_busy_max) else $error("write stuck");
    property p_osc_off;
        !OSC_EN && !WR_BUSY |=> !WR_BUSY;
    endproperty
    a_osc_off: assert property (p_osc_off) else $error("write taken");

    // ********************************
    // Events, wakeup pin and time ranges
    // ********************************
    property p_irq;
        IRQ == (ALARM_FLAG || PER_FLAG);
    endproperty
    a_irq: assert property (p_irq) else $error("irq not flag merge");
    property p_wake_flags;
        ALARM_FLAG || PER_FLAG |-> WAKE_REQ;
    endproperty
    a_wake_flags: assert property (p_wake_flags) else $error("no wake");
    property p_wake_in;
        (!WU_DIR && WAKEUP_I) [*4] |-> WAKE_REQ;
    endproperty
    a_wake_in: assert property (p_wake_in) else $error("input wake");
    property p_dir_in;
        !WU_DIR [*2] |-> !WAKEUP_OE;
    endproperty
    a_dir_in: assert property (p_dir_in) else $error("pin driven");
    property p_drive_lo;
        (WU_DIR && !WU_DOUT) [*2] |-> WAKEUP_OE;
    endproperty
    a_drive_lo: assert property (p_drive_lo) else $error("pin not low");
    property p_per_clr;
        !PER_EN ##1 (!PER_EN && PER_CLR) |=> !PER_FLAG;
    endproperty
    a_per_clr: assert property (p_per_clr) else $error("flag kept");
    property p_bcd;
        TIME.sec <= SEC_MAX && TIME.min <= SEC_MAX
            && TIME.hour <= HOUR_MAX && TIME.ms <= MS_MAX;
    endproperty
    a_bcd: assert property (p_bcd) else $error("time out of range");
endmodule

bind rtc_core rtc_core_checker u_chk (.CLK, .SRST, .OSC_EN, .POWERGOOD,
    .WR_STB, .PER_EN, .PER_CLR, .WU_DIR, .WU_DOUT, .WAKEUP_I, .TIME,
    .WR_BUSY, .ALARM_FLAG, .PER_FLAG, .IRQ, .WAKE_REQ, .WAKEUP_OE);

/* rtc_core_bench.sv */
// Self-checking bench for the calendar clock core.
// Assumes rtc_pkg, rtc_core and the bound checker are compiled first.
`timescale 1ns/10ps
module rtc_core_bench
    import rtc_pkg::*;
;
    // ********************************
    // Signals
    // ********************************
    logic              clk, srst, osc_en, pg, wr_stb, alarm_en, alarm_clr;
    logic              per_en, per_clr, wu_dir, wu_dout, wake_i;
    logic [1:0]        xph = 2'h0;
    wr_t               wr;
    logic signed [7:0] cal;
    alarm_mode_t       amode;
    per_sel_t          psel;
    rtc_time_t         tm;
    alarm_t            al;
    logic              busy, aflag, pflag, irq, wreq, wu_o, wu_oe;
    int                fail_count, total_checks;
    wire               xtal = (xph == 2'h0);

    // Clock and a fast crystal stand-in, a third of the CLK rate
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(negedge clk)
        xph <= (xph == 2'h2) ? 2'h0 : xph + 2'h1;

    rtc_core DUT (
        .CLK(clk), .SRST(srst), .XTAL_CLK(xtal), .OSC_EN(osc_en),
        .POWERGOOD(pg), .WR_STB(wr_stb), .WR(wr), .CAL(cal),
        .ALARM_MODE(amode), .ALARM_EN(alarm_en), .ALARM_CLR(alarm_clr),
        .PER_SEL(psel), .PER_EN(per_en), .PER_CLR(per_clr),
        .WU_DIR(wu_dir), .WU_DOUT(wu_dout), .WAKEUP_I(wake_i),
        .TIME(tm), .ALARM(al), .WR_BUSY(busy), .ALARM_FLAG(aflag),
        .PER_FLAG(pflag), .IRQ(irq), .WAKE_REQ(wreq), .WAKEUP_O(wu_o),
        .WAKEUP_OE(wu_oe)
    );

    // ********************************
    // Helpers
    // ********************************
    task automatic chk_v(input logic [67:0] g, input logic [67:0] e);
        total_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // One write; b is the busy level expected after the take edge
    task automatic wr_do(input wsel_t s, input logic [7:0] d, input logic b);
        int i;
        wr = '{s, d};
        wr_stb = 1'b1;
        @(negedge clk);
        wr_stb = 1'b0;
        chk_v(busy, b);
        for (i = 0; i < 300 && busy !== 1'b0; i++)
            @(negedge clk);
    endtask

    // ********************************
    // Scenarios
    // ********************************
    task automatic t_reset;
        chk_v(tm, {8'h00, 8'h01, 8'h01, 8'h01, 24'h0, 12'h0});
        chk_v({al, busy, aflag, pflag, irq, wreq, wu_oe}, 38'h0040000000);
        $display("end reset");
    endtask
    task automatic t_refuse;
        osc_en = 1'b0;
        cyc(2);
        wr_do(W_MIN, 8'h11, 1'b0);
        cyc(20);
        osc_en = 1'b1;
        cyc(20);
        chk_v(tm.min, 8'h00);
        pg = 1'b0;
        cyc(4);
        wr_do(W_MIN, 8'h22, 1'b0);
        pg = 1'b1;
        cyc(4);
        chk_v(tm.min, 8'h00);
        $display("end refuse");
    endtask
    task automatic t_write;
        wsel_t      ws [8] = '{W_YEAR, W_MON, W_DAY, W_HOUR, W_MIN,
                               W_AHOUR, W_AMIN, W_ASEC};
        logic [7:0] wd [8] = '{8'h99, 8'h12, 8'h31, 8'h23, 8'h59,
                               8'h23, 8'h59, 8'h01};
        for (int i = 0; i < 8; i++)
            wr_do(ws[i], wd[i], 1'b1);
        chk_v({tm.year, tm.mon, tm.day, tm.hour, tm.min}, 40'h9912312359);
        chk_v({al.hour, al.min, al.sec}, 24'h235901);
        $display("end write");
    endtask
    task automatic t_wake;
        wake_i = 1'b1;
        cyc(6);
        chk_v(wreq, 1'b1);
        wake_i = 1'b0;
        cyc(4);
        chk_v(wreq, 1'b0);
        wu_dir = 1'b1;
        wu_dout = 1'b0;
        cyc(2);
        chk_v({wu_oe, wu_o}, 2'h2);
        wu_dout = 1'b1;
        wake_i = 1'b1;
        cyc(6);
        chk_v({wu_oe, wreq}, 2'h0);
        wake_i = 1'b0;
        $display("end wake");
    endtask
    task automatic t_per;
        int i;
        per_en = 1'b1;
        for (i = 1; i < 5; i++)
        begin
            psel = per_sel_t'(i);
            cyc(150);
            chk_v(pflag, 1'b0);
        end
        psel = PER_MS;
        for (i = 0; i < 300 && pflag !== 1'b1; i++)
            @(negedge clk);
        chk_v({pflag, irq, wreq, wu_oe}, 4'hf);
        per_en = 1'b0;
        cyc(2);
        per_clr = 1'b1;
        cyc(1);
        per_clr = 1'b0;
        cyc(1);
        chk_v({pflag, irq, wu_oe}, 3'h0);
        $display("end periodic");
    endtask
    task automatic t_alarm;
        logic [11:0] last;
        int          i;
        cal = 8'sh7f;
        amode = AL_DAY;
        alarm_en = 1'b1;
        psel = PER_SEC;
        per_en = 1'b1;
        for (i = 0; i < 100000 && tm.sec !== 8'h01; i++)
        begin
            last = tm.ms;
            @(negedge clk);
        end
        chk_v(last, 12'h368);
        chk_v({tm.sec, tm.ms}, 20'h01000);
        cyc(2);
        chk_v({aflag, pflag, irq, wreq, wu_oe}, 5'h1f);
        alarm_en = 1'b0;
        per_en = 1'b0;
        alarm_clr = 1'b1;
        per_clr = 1'b1;
        cyc(1);
        alarm_clr = 1'b0;
        per_clr = 1'b0;
        cyc(1);
        chk_v({aflag, pflag, irq}, 3'h0);
        $display("end alarm");
    endtask

    // ********************************
    // Run control
    // ********************************
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Tests take about 86000 cycles; give up after 98000
    initial
    begin
        #980000;
        fail_count++;
        close_out();
    end
    initial
    begin
        {srst, osc_en, pg, wu_dout} = 4'hf;
        {wr_stb, alarm_en, alarm_clr, per_en, per_clr, wu_dir} = 6'h0;
        wake_i = 1'b0;
        wr = '{W_SEC, 8'h00};
        cal = 8'sh00;
        amode = AL_SEC;
        psel = PER_MS;
        repeat (3) @(negedge clk);
        srst = 1'b0;
        t_reset();
        t_refuse();
        t_write();
        t_wake();
        t_per();
        t_alarm();
        close_out();
    end
endmodule
